// *** common/ocdc_defs.vh ***
`ifndef OCDC_DEFS_VH
`define OCDC_DEFS_VH
// ****************************************
// Command opcodes
// ****************************************
`define OCDC_OP_WR_CTL  8'h04
`define OCDC_OP_RD_CTL  8'h05
`define OCDC_OP_WR_PC   8'h06
`define OCDC_OP_RD_PC   8'h07
`define OCDC_OP_WR_REG  8'h08
`define OCDC_OP_RD_REG  8'h09
`define OCDC_OP_WR_WPT  8'h20
`define OCDC_OP_RD_WPT  8'h21
// ****************************************
// Field positions and reset values
// ****************************************
`define OCDC_CTL_DEBUG_MODE_FLAG_BIT 7
`define OCDC_WPT_WRITE_BIT   7
`define OCDC_WPT_READ_BIT    6
`define OCDC_WPT_DMATCH_BIT  5
`define OCDC_WPT_RSVD_BIT    4
`define OCDC_CTL_RESET       8'h00
`define OCDC_WPT_RESET       8'h00
`define OCDC_PC_BLOCKED      16'hFFFF
// Flash control register page window, upper 8 address bits
`define OCDC_FLASH_PAGE      8'hFF
`define OCDC_FLASH_LO_BASE   4'h8
`endif

// *** hw/ocdc_ctrl.v ***
`timescale 1ns/1ps
`include "ocdc_defs.vh"
// Behaviour
// - In debug mode, halt CPU fetch except for controller-directed instructions.
// - Debug mode never gates system clock or peripherals.
// - Entering debug mode forces the core out of halt.
// - While in debug mode, refresh the watchdog continuously when enabled.
// - Host writing debug-mode bit as 1 enters debug mode.
// - Breakpoint instruction enters debug mode when breakpoints are enabled.
// - A matching watchpoint enters debug mode.
// - Debug pin low when reset releases enters debug mode.
// - Clearing the debug-mode bit leaves debug mode.
// - Opcode 04H plus one byte loads the control register.
// - Under read protection the debug-mode bit can be set, never cleared.
// - Opcode 05H returns the control register value.
// - Opcode 06H takes PC high, low; dropped outside debug or protected.
// - Opcode 07H returns PC high, low, or FFFFH when blocked.
// - Opcode 08H: address high nibble, address low, size, data; size 0 is 256.
// - Register writes outside debug mode are discarded.
// - Under read protection only flash control register writes pass.
// - Opcode 09H returns 1 to 256 register bytes per size.
// - Watch bit 7 breaks on writes to watched address; not settable protected.
// - Watch bit 6 breaks on reads of watched address; not settable protected.
// - Watch bit 5 adds data match; needs read or write enable.
// - Watch address is bits 3:0 of watch control plus low register; bit 4 zero.
module ocdc_ctrl (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // Serial byte link (from the receiver and transmitter)
  input  wire        rx_valid_in,
  input  wire [7:0]  rx_data_in,
  output reg         tx_valid_out,
  output reg  [7:0]  tx_data_out,
  input  wire        tx_ready_in,
  // Pins and option bits
  input  wire        debug_serial_pin_in,
  input  wire        read_protect_flag_in,
  input  wire        brk_enable_in,
  input  wire        wdt_enable_in,
  // Core side
  input  wire        breakpoint_opcode_in,
  input  wire [15:0] cpu_pc_in,
  output reg         pc_load_out,
  output reg  [15:0] pc_data_out,
  output wire        fetch_stop_out,
  output wire        halt_exit_out,
  output wire        wdt_refresh_out,
  output wire        clock_gate_out,
  output wire        debug_mode_flag_out,
  // Register file access from the core, watched for breaks
  input  wire        rf_cpu_wr_in,
  input  wire        rf_cpu_rd_in,
  input  wire [11:0] rf_cpu_addr_in,
  input  wire [7:0]  rf_cpu_data_in,
  // Register file port of the debugger
  output reg         rf_wr_out,
  output reg         rf_rd_out,
  output reg  [11:0] rf_addr_out,
  output reg  [7:0]  rf_wdata_out,
  input  wire [7:0]  rf_rdata_in,
  // Watch data value, from the watch data register of the core
  input  wire [7:0]  watch_data_in
);
  // ****************************************
  // Command sequencer states
  // ****************************************
  localparam ST_IDLE  = 4'h0;
  localparam ST_ARG1  = 4'h1;
  localparam ST_ARG2  = 4'h2;
  localparam ST_ARG3  = 4'h3;
  localparam ST_DATA  = 4'h4;
  localparam ST_SEND1 = 4'h5;
  localparam ST_SEND2 = 4'h6;
  localparam ST_RDREQ = 4'h7;
  localparam ST_RDSND = 4'h8;
  localparam [15:0] PC_BLOCKED = `OCDC_PC_BLOCKED;

  reg  [3:0]  state_r;
  reg  [7:0]  op_r;
  reg  [7:0]  debugger_control_reg_r;
  reg  [7:0]  watch_control_reg_r;
  reg  [7:0]  watch_addr_low_reg_r;
  reg  [7:0]  arg_r;
  reg  [11:0] addr_r;
  reg  [8:0]  count_r;
  reg  [7:0]  hold_r;
  reg  [2:0]  strap_win_r;
  wire        dbg_pin_sync;
  wire        debug_mode_flag;
  wire        protect;
  wire [11:0] watch_addr;
  wire        watch_hit;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  ocdc_pin_sync #(
    .RESET_VAL (1'b1)
  ) u_pin_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .pin_in   (debug_serial_pin_in),
    .sync_out (dbg_pin_sync)
  );

  assign debug_mode_flag     = debugger_control_reg_r[`OCDC_CTL_DEBUG_MODE_FLAG_BIT];
  assign protect             = read_protect_flag_in;
  assign debug_mode_flag_out = debug_mode_flag;
  assign fetch_stop_out      = debug_mode_flag;
  assign clock_gate_out      = 1'b0;
  assign halt_exit_out       = debug_mode_flag;
  assign wdt_refresh_out     = debug_mode_flag & wdt_enable_in;

  // Watched address is the nibble field plus the low register
  assign watch_addr = {watch_control_reg_r[3:0], watch_addr_low_reg_r};

  // Data match only qualifies an enabled read or write break
  function data_ok;
    input [7:0] d;
    begin
      data_ok = ~watch_control_reg_r[`OCDC_WPT_DMATCH_BIT] | (d == watch_data_in);
    end
  endfunction

  assign watch_hit = (rf_cpu_addr_in == watch_addr) & data_ok(rf_cpu_data_in) &
    ((rf_cpu_wr_in & watch_control_reg_r[`OCDC_WPT_WRITE_BIT]) |
     (rf_cpu_rd_in & watch_control_reg_r[`OCDC_WPT_READ_BIT]));

  // Flash control registers sit at the top of the peripheral page
  function flash_reg;
    input [11:0] a;
    begin
      flash_reg = (a[11:4] == `OCDC_FLASH_PAGE) & (a[3:0] >= `OCDC_FLASH_LO_BASE);
    end
  endfunction

  // Clears the control bits that protection forbids setting
  function [7:0] wpt_filter;
    input [7:0] v;
    begin
      wpt_filter = v;
      wpt_filter[`OCDC_WPT_RSVD_BIT] = 1'b0;
      if (protect) begin
        wpt_filter[7:5] = 3'h0;
      end
    end
  endfunction

  // ****************************************
  // Debug mode and entry sources
  // ****************************************
  // Pin strap is judged three clocks after release, once both sync flops hold
  // the level seen at release; their reset value must never count as a strap
  always @(posedge mclk_in) begin
    if (rst_in) begin
      strap_win_r            <= 3'h1;
      debugger_control_reg_r <= `OCDC_CTL_RESET;
    end else begin
      strap_win_r <= {strap_win_r[1:0], 1'b0};
      if (state_r == ST_ARG1 && rx_valid_in && op_r == `OCDC_OP_WR_CTL) begin
        debugger_control_reg_r <= rx_data_in;
        if (protect && debug_mode_flag) begin
          debugger_control_reg_r[`OCDC_CTL_DEBUG_MODE_FLAG_BIT] <= 1'b1;
        end
      end
      // Hardware entries win over a same-cycle host clear
      if ((strap_win_r[2] && !dbg_pin_sync) ||
          (breakpoint_opcode_in && brk_enable_in) ||
          watch_hit) begin
        debugger_control_reg_r[`OCDC_CTL_DEBUG_MODE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  // One command at a time; bytes arriving during replies are ignored
  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_r              <= ST_IDLE;
      op_r                 <= 8'h00;
      arg_r                <= 8'h00;
      addr_r               <= 12'h000;
      count_r              <= 9'h000;
      hold_r               <= 8'h00;
      tx_valid_out         <= 1'b0;
      tx_data_out          <= 8'h00;
      pc_load_out          <= 1'b0;
      pc_data_out          <= 16'h0000;
      rf_wr_out            <= 1'b0;
      rf_rd_out            <= 1'b0;
      rf_addr_out          <= 12'h000;
      rf_wdata_out         <= 8'h00;
      watch_control_reg_r  <= `OCDC_WPT_RESET;
      watch_addr_low_reg_r <= 8'h00;
    end else begin
      pc_load_out <= 1'b0;
      rf_wr_out   <= 1'b0;
      rf_rd_out   <= 1'b0;
      if (tx_valid_out && tx_ready_in) begin
        tx_valid_out <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (rx_valid_in) begin
            op_r <= rx_data_in;
            case (rx_data_in)
              `OCDC_OP_WR_CTL, `OCDC_OP_WR_PC, `OCDC_OP_WR_REG,
              `OCDC_OP_RD_REG, `OCDC_OP_WR_WPT: begin
                state_r <= ST_ARG1;
              end
              `OCDC_OP_RD_CTL: begin
                tx_valid_out <= 1'b1;
                tx_data_out  <= debugger_control_reg_r;
                state_r      <= ST_SEND2;
              end
              `OCDC_OP_RD_PC: begin
                tx_valid_out <= 1'b1;
                if (!debug_mode_flag || protect) begin
                  tx_data_out <= PC_BLOCKED[15:8];
                  hold_r      <= PC_BLOCKED[7:0];
                end else begin
                  tx_data_out <= cpu_pc_in[15:8];
                  hold_r      <= cpu_pc_in[7:0];
                end
                state_r <= ST_SEND1;
              end
              `OCDC_OP_RD_WPT: begin
                tx_valid_out <= 1'b1;
                tx_data_out  <= watch_control_reg_r;
                hold_r       <= watch_addr_low_reg_r;
                state_r      <= ST_SEND1;
              end
              default: begin
                state_r <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ARG1: begin
          if (rx_valid_in) begin
            arg_r   <= rx_data_in;
            state_r <= (op_r == `OCDC_OP_WR_CTL) ? ST_IDLE : ST_ARG2;
          end
        end
        ST_ARG2: begin
          if (rx_valid_in) begin
            if (op_r == `OCDC_OP_WR_PC) begin
              pc_data_out <= {arg_r, rx_data_in};
              pc_load_out <= debug_mode_flag & ~protect;
              state_r     <= ST_IDLE;
            end else if (op_r == `OCDC_OP_WR_WPT) begin
              watch_control_reg_r  <= wpt_filter(arg_r);
              watch_addr_low_reg_r <= rx_data_in;
              state_r              <= ST_IDLE;
            end else begin
              addr_r  <= {arg_r[3:0], rx_data_in};
              state_r <= ST_ARG3;
            end
          end
        end
        ST_ARG3: begin
          if (rx_valid_in) begin
            count_r <= (rx_data_in == 8'h00) ? 9'h100 : {1'b0, rx_data_in};
            state_r <= (op_r == `OCDC_OP_WR_REG) ? ST_DATA : ST_RDREQ;
          end
        end
        ST_DATA: begin
          if (rx_valid_in) begin
            rf_addr_out  <= addr_r;
            rf_wdata_out <= rx_data_in;
            rf_wr_out    <= debug_mode_flag &
                            (~protect | flash_reg(addr_r));
            addr_r       <= addr_r + 12'h001;
            count_r      <= count_r - 9'h001;
            if (count_r == 9'h001) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RDREQ: begin
          // Read data is taken one cycle after the strobe
          rf_addr_out <= addr_r;
          rf_rd_out   <= 1'b1;
          state_r     <= ST_RDSND;
        end
        ST_RDSND: begin
          if (!rf_rd_out && (!tx_valid_out || tx_ready_in)) begin
            tx_valid_out <= 1'b1;
            tx_data_out  <= rf_rdata_in;
            addr_r       <= addr_r + 12'h001;
            count_r      <= count_r - 9'h001;
            state_r      <= (count_r == 9'h001) ? ST_SEND2 : ST_RDREQ;
          end
        end
        ST_SEND1: begin
          if (tx_ready_in) begin
            tx_valid_out <= 1'b1;
            tx_data_out  <= hold_r;
            state_r      <= ST_SEND2;
          end
        end
        ST_SEND2: begin
          if (tx_ready_in) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // ocdc_ctrl

// *** hw/ocdc_pin_sync.v ***
`timescale 1ns/1ps
// ****************************************
// Two-stage pin synchroniser
// ****************************************
module ocdc_pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire mclk_in,
  input  wire rst_in,
  // Pin and synchronised level
  input  wire pin_in,
  output wire sync_out
);
  reg meta_r;
  reg sync_r;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule // ocdc_pin_sync

// *** tb/ocdc_ctrl_assertions.sv ***
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module ocdc_chk (
  input logic mclk_in, rst_in, tx_valid_out, tx_ready_in, debug_serial_pin_in,
  input logic read_protect_flag_in, brk_enable_in, wdt_enable_in, breakpoint_opcode_in,
  input logic pc_load_out, fetch_stop_out, halt_exit_out, wdt_refresh_out,
  input logic clock_gate_out, debug_mode_flag_out, rf_wr_out,
  input logic [7:0]  tx_data_out,
  input logic [11:0] rf_addr_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  chk_fetch_idle: assert property (fetch_stop_out == debug_mode_flag_out)
    else $error("fetch stop differs from debug mode");
  chk_clock_free: assert property (!clock_gate_out)
    else $error("clock gated");
  chk_halt_exit: assert property ($rose(debug_mode_flag_out) |-> halt_exit_out)
    else $error("halt not left on debug entry");
  chk_wdt_kick: assert property (wdt_refresh_out == (debug_mode_flag_out && wdt_enable_in))
    else $error("watchdog refresh wrong");
  chk_brk_entry: assert property (breakpoint_opcode_in && brk_enable_in |-> ##[1:3] debug_mode_flag_out)
    else $error("breakpoint did not enter debug");
  chk_pin_strap: assert property ($fell(rst_in) && !debug_serial_pin_in |-> ##[1:4] debug_mode_flag_out)
    else $error("strap did not enter debug");
  chk_prot_hold: assert property ($fell(debug_mode_flag_out) |-> !$past(read_protect_flag_in))
    else $error("debug left under protection");
  chk_pc_gate: assert property (pc_load_out |-> debug_mode_flag_out && !read_protect_flag_in)
    else $error("pc load not allowed");
  chk_rf_gate: assert property (rf_wr_out |-> debug_mode_flag_out)
    else $error("register write outside debug");
  chk_flash_only: assert property (rf_wr_out && read_protect_flag_in |-> rf_addr_out[11:3] == 9'h1FF)
    else $error("protected write off flash regs");
  chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte not held");
  cov_brk: cover property (breakpoint_opcode_in && brk_enable_in ##2 debug_mode_flag_out);
  cov_stall: cover property (tx_valid_out && !tx_ready_in ##1 tx_valid_out && tx_ready_in);
  cov_flash: cover property (rf_wr_out && read_protect_flag_in);
endmodule // ocdc_chk
bind ocdc_ctrl ocdc_chk u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in), .debug_serial_pin_in(debug_serial_pin_in),
  .read_protect_flag_in(read_protect_flag_in), .brk_enable_in(brk_enable_in),
  .wdt_enable_in(wdt_enable_in), .breakpoint_opcode_in(breakpoint_opcode_in),
  .pc_load_out(pc_load_out), .fetch_stop_out(fetch_stop_out),
  .halt_exit_out(halt_exit_out), .wdt_refresh_out(wdt_refresh_out),
  .clock_gate_out(clock_gate_out), .debug_mode_flag_out(debug_mode_flag_out),
  .rf_wr_out(rf_wr_out), .tx_data_out(tx_data_out), .rf_addr_out(rf_addr_out)
);

// *** tb/ocdc_host.sv ***
`timescale 1ns/1ps
// ****************
// Debug host model
// ****************
module ocdc_host (
  input  logic       mclk_in,
  input  logic       tx_valid_out,
  input  logic [7:0] tx_data_out,
  output logic       rx_valid_in,
  output logic       tx_ready_in,
  output logic [7:0] rx_data_in
);
  initial begin
    rx_valid_in = 0;
    tx_ready_in = 0;
    rx_data_in = 8'hA5;
  end
  // Released line shows the inverse, so a stale byte is never reused
  task send(input logic [7:0] b);
    @(posedge mclk_in);
    #1 rx_valid_in = 1;
    rx_data_in = b;
    @(posedge mclk_in);
    #1 rx_valid_in = 0;
    rx_data_in = ~b;
  endtask
  // Stalls st+1 cycles before accepting a reply byte
  task recv(input int st, output logic [7:0] b, output bit to);
    int n;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (!tx_valid_out && n < 60);
    to = !tx_valid_out;
    repeat (st + 1) @(posedge mclk_in);
    #1 tx_ready_in = 1;
    @(negedge mclk_in);
    b = tx_data_out;
    @(posedge mclk_in);
    #1 tx_ready_in = 0;
  endtask
endmodule // ocdc_host

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  logic mclk_in, rst_in, pin, rpf, brk_en, wdt_en, bp, cw, cr;
  logic [11:0] ca, la;
  logic [7:0]  cd, wdat, rdat, ld;
  logic [15:0] pc, pc_got;
  wire         rxv, txv, txr, pl, dbg, rfw, rfr;
  wire  [11:0] rfa;
  wire  [7:0]  rfd, txd, rxd;
  wire  [15:0] pcd;
  int          fails, compares, wn, pn;
  ocdc_ctrl u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .rx_valid_in(rxv), .rx_data_in(rxd),
    .tx_valid_out(txv), .tx_data_out(txd), .tx_ready_in(txr), .debug_serial_pin_in(pin),
    .read_protect_flag_in(rpf), .brk_enable_in(brk_en), .wdt_enable_in(wdt_en),
    .breakpoint_opcode_in(bp), .cpu_pc_in(pc), .pc_load_out(pl), .pc_data_out(pcd),
    .fetch_stop_out(), .halt_exit_out(), .wdt_refresh_out(), .clock_gate_out(),
    .debug_mode_flag_out(dbg), .rf_cpu_wr_in(cw), .rf_cpu_rd_in(cr), .rf_cpu_addr_in(ca),
    .rf_cpu_data_in(cd), .rf_wr_out(rfw), .rf_rd_out(rfr), .rf_addr_out(rfa),
    .rf_wdata_out(rfd), .rf_rdata_in(rdat), .watch_data_in(wdat));
  ocdc_host u_host (.mclk_in(mclk_in), .tx_valid_out(txv), .tx_data_out(txd),
    .rx_valid_in(rxv), .tx_ready_in(txr), .rx_data_in(rxd));
  initial begin
    mclk_in = 0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Register file answers one cycle after a read, otherwise shows junk
  always @(posedge mclk_in) begin
    rdat <= rfr ? rfa[7:0] ^ 8'h5A : ~rdat;
    if (rfw) begin
      wn <= wn + 1;
      la <= rfa;
      ld <= rfd;
    end
    if (pl) begin
      pn <= pn + 1;
      pc_got <= pcd;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task snd(input logic [7:0] q[$]);
    foreach (q[i]) u_host.send(q[i]);
    tick(3);
  endtask
  task get(input logic [7:0] e, input int st);
    logic [7:0] g;
    bit to;
    u_host.recv(st, g, to);
    if (to) begin
      fails++;
      conclude;
    end
    `CK(g, e)
  endtask
  task cpu(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1 cw = w;
    cr = !w;
    ca = a;
    cd = d;
    tick(1);
    cw = 0;
    cr = 0;
    ca = ~a;
    tick(3);
  endtask
  task breakpoint_opcode(input logic en);
    brk_en = en;
    tick(1);
    bp = 1;
    tick(1);
    bp = 0;
    tick(3);
  endtask
  task conclude;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    rst_in = 1; pin = 0; rpf = 0; brk_en = 0; wdt_en = 1; bp = 0; cw = 0; cr = 0;
    ca = 0; cd = 0; wdat = 8'h55; pc = 16'h1234; rdat = 0; la = 0; ld = 0;
    fails = 0; compares = 0; wn = 0; pn = 0;
    tick(5);
    rst_in = 0;
    tick(4);
    pin = 1;
    `CK(dbg, 1'b1)
    snd('{8'h05});
    get(8'h80, 0);
    snd('{8'h04, 8'h00});
    `CK(dbg, 1'b0)
    snd('{8'h07});
    get(8'hFF, 0);
    get(8'hFF, 0);
    snd('{8'h06, 8'h12, 8'h34});
    snd('{8'h08, 8'h01, 8'h00, 8'h01, 8'h77});
    `CK(pn + wn, 0)
    snd('{8'h04, 8'h80});
    `CK(dbg, 1'b1)
    snd('{8'h05});
    get(8'h80, 2);
    wdt_en = 0;
    snd('{8'h07});
    get(8'h12, 3);
    get(8'h34, 0);
    snd('{8'h06, 8'hAB, 8'hCD});
    `CK(pc_got, 16'hABCD)
    snd('{8'h08, 8'h0F, 8'h0E, 8'h02, 8'h11, 8'h22});
    `CK({wn, la, ld}, {32'd2, 12'hF0F, 8'h22})
    snd('{8'h08, 8'h02, 8'h00, 8'h00});
    for (int i = 0; i < 256; i++) u_host.send(i[7:0]);
    tick(3);
    `CK({wn, la, ld}, {32'd258, 12'h2FF, 8'hFF})
    snd('{8'h09, 8'h01, 8'h23, 8'h03});
    for (int i = 0; i < 3; i++) get((8'h23 + i[7:0]) ^ 8'h5A, 1);
    snd('{8'h20, 8'h93, 8'h40});
    snd('{8'h21});
    get(8'h83, 0);
    get(8'h40, 0);
    snd('{8'h04, 8'h00});
    cpu(1, 12'h341, 8'h55);
    cpu(0, 12'h340, 8'h55);
    `CK(dbg, 1'b0)
    cpu(1, 12'h340, 8'h12);
    `CK(dbg, 1'b1)
    snd('{8'h20, 8'hA3, 8'h40});
    snd('{8'h04, 8'h00});
    cpu(1, 12'h340, 8'h54);
    `CK(dbg, 1'b0)
    cpu(1, 12'h340, 8'h55);
    `CK(dbg, 1'b1)
    snd('{8'h20, 8'h43, 8'h40});
    snd('{8'h04, 8'h00});
    cpu(0, 12'h340, 8'h99);
    `CK(dbg, 1'b1)
    snd('{8'h04, 8'h00});
    breakpoint_opcode(0);
    `CK(dbg, 1'b0)
    breakpoint_opcode(1);
    `CK(dbg, 1'b1)
    rpf = 1;
    snd('{8'h04, 8'h00});
    `CK(dbg, 1'b1)
    snd('{8'h07});
    get(8'hFF, 0);
    get(8'hFF, 0);
    snd('{8'h06, 8'h55, 8'h66});
    snd('{8'h08, 8'h01, 8'h00, 8'h01, 8'h77});
    `CK({pn, wn}, {32'd1, 32'd258})
    snd('{8'h08, 8'h0F, 8'hF8, 8'h01, 8'h3C});
    `CK({wn, la, ld}, {32'd259, 12'hFF8, 8'h3C})
    snd('{8'h20, 8'hE3, 8'h40});
    snd('{8'h21});
    get(8'h03, 0);
    get(8'h40, 0);
    rst_in = 1;
    tick(5);
    rst_in = 0;
    rpf = 0;
    tick(4);
    `CK(dbg, 1'b0)
    snd('{8'h05});
    get(8'h00, 0);
    conclude;
  end
endmodule // testbench
